// ---- src/abx_consts.vh ----
// Purpose: Constants for the abx instruction execution core.
// Assumes: 16-bit instruction words, 8-bit data, 16-bit program counter.
// Notes: Opcode field is instruction bits 15:12; sub-operation fields are listed per group.
`ifndef ABX_CONSTS_VH
`define ABX_CONSTS_VH

// Major opcodes, instruction bits 15:12.
`define ABX_OP_REGREG 4'h0
`define ABX_OP_SUBTRACT_IMMEDIATE 4'h1
`define ABX_OP_SUBTRACT_BORROW_IMMEDIATE 4'h2
`define ABX_OP_AND_IMMEDIATE 4'h3
`define ABX_OP_BIT_SET_MASK 4'h4
`define ABX_OP_BIT_CLEAR_MASK 4'h5
`define ABX_OP_COMPARE_IMMEDIATE 4'h6
`define ABX_OP_WORD 4'h7
`define ABX_OP_SINGLE 4'h8
`define ABX_OP_IO_SKIP 4'h9
`define ABX_OP_BRANCH 4'hA
`define ABX_OP_RELATIVE_CALL 4'hB
`define ABX_OP_MISC 4'hC
`define ABX_OP_LONG 4'hF

// Sub-operations of the register-to-register group, bits 11:10.
`define ABX_RR_ADD_CARRY 2'h0
`define ABX_RR_SUBTRACT_BORROW_REGS 2'h1
`define ABX_RR_COMPARE_SKIP_EQUAL 2'h2

// Sub-operations of the single-register group, bits 11:10.
`define ABX_SG_DECREMENT 2'h0
`define ABX_SG_ZERO_SIGN_TEST 2'h1
`define ABX_SG_SKIP_IF_REG_BIT_CLEAR 2'h2
`define ABX_SG_SKIP_IF_REG_BIT_SET 2'h3

// Miscellaneous group, bits 3:0.
`define ABX_MS_JUMP_VIA_Z 4'h0
`define ABX_MS_CALL_VIA_Z 4'h1
`define ABX_MS_SUBROUTINE_EXIT 4'h2
`define ABX_MS_INTERRUPT_EXIT 4'h3

// Bit positions in status_flags.
`define ABX_FLAG_C 0
`define ABX_FLAG_Z 1
`define ABX_FLAG_N 2
`define ABX_FLAG_V 3
`define ABX_FLAG_S 4
`define ABX_FLAG_H 5
`define ABX_FLAG_T 6
`define ABX_FLAG_I 7

// Cycle counts per instruction class.
`define ABX_CYC_WORD 3'h2
`define ABX_CYC_JUMP 3'h2
`define ABX_CYC_CALL 3'h3
`define ABX_CYC_RET 3'h4
`define ABX_CYC_LONG 3'h2

// Reset values and structure.
`define ABX_PC_RESET 16'h0000
`define ABX_FLAGS_RESET 8'h00
`define ABX_REG_Z_LOW 5'h1E
`define ABX_REG_Z_HIGH 5'h1F
`define ABX_STACK_DEPTH 16

`endif

// ---- src/abx_exec_core.v ----
// Purpose: Executes arithmetic, logic, compare, skip, jump, call and branch instructions.
// Assumes: Program memory answers i_pm_data for o_pm_addr in the same cycle.
// Notes: The I/O space is presented as a flat bit vector, 64 registers of 8 bits.
`timescale 1ns/1ps
`include "abx_consts.vh"

module abx_exec_core
(
  input wire i_sys_clk,
  input wire i_sys_rst,
  input wire [15:0] i_pm_data,
  input wire [511:0] i_io_regs,
  output reg [15:0] o_pm_addr,
  output reg [7:0] o_status_flags,
  output reg o_wr_valid,
  output reg [4:0] o_wr_addr,
  output reg [15:0] o_wr_data,
  output reg o_busy
);

  localparam ST_EXEC = 2'b00;
  localparam ST_SKIP = 2'b01;
  localparam ST_STALL = 2'b10;

  reg [7:0] regs [0:31];
  reg [15:0] stack [0:`ABX_STACK_DEPTH-1];
  reg [3:0] sp;
  reg [1:0] state;
  reg [2:0] cnt;
  integer i;

  reg [1:0] next_state;
  reg [2:0] next_cnt;
  reg [15:0] next_pc;
  reg [7:0] next_flags;
  reg next_we;
  reg next_wword;
  reg [4:0] next_waddr;
  reg [15:0] next_wdata;
  reg next_push;
  reg next_pop;
  reg [10:0] hvcr;
  reg [16:0] wsum;
  reg [7:0] da;

  wire [3:0] op = i_pm_data[15:12];
  wire [1:0] sub = i_pm_data[11:10];
  wire [4:0] rd = i_pm_data[9:5];
  wire [4:0] rr = i_pm_data[4:0];
  wire [4:0] hd = {1'b1, i_pm_data[11:8]};
  wire [7:0] kimm = i_pm_data[7:0];
  wire [4:0] wlo = {2'b11, i_pm_data[10:9], 1'b0};
  wire [4:0] whi = {2'b11, i_pm_data[10:9], 1'b1};
  wire [15:0] wval = {regs[whi], regs[wlo]};
  wire [15:0] wk = {10'h000, i_pm_data[5:0]};
  wire [15:0] zptr = {regs[`ABX_REG_Z_HIGH], regs[`ABX_REG_Z_LOW]};
  wire [15:0] pc_inc = o_pm_addr + 16'h0001;
  wire [15:0] br_target = pc_inc + {{9{i_pm_data[9]}}, i_pm_data[9:3]};
  wire [15:0] call_target = pc_inc + {{4{i_pm_data[11]}}, i_pm_data[11:0]};
  wire [3:0] sp_top = sp - 4'h1;

  // Result layout for both: half-carry, overflow, carry, then the 8-bit result.
  function [10:0] abx_add8;
    input [7:0] a;
    input [7:0] b;
    input ci;
    reg [7:0] r;
    begin
      r = a + b + {7'h00, ci};
      abx_add8 = {(a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]),
        (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]),
        (a[7] & b[7]) | (b[7] & ~r[7]) | (~r[7] & a[7]), r};
    end
  endfunction

  function [10:0] abx_sub8;
    input [7:0] a;
    input [7:0] b;
    input ci;
    reg [7:0] r;
    begin
      r = a - b - {7'h00, ci};
      abx_sub8 = {(~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]),
        (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]),
        (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]), r};
    end
  endfunction

  // Borrow-chained subtracts keep Z only if it was already set, so a
  // multi-byte compare reports zero only when every byte was zero.
  function [7:0] abx_aflags;
    input [7:0] f;
    input [10:0] x;
    input chain;
    begin
      abx_aflags = f;
      abx_aflags[`ABX_FLAG_H] = x[10];
      abx_aflags[`ABX_FLAG_V] = x[9];
      abx_aflags[`ABX_FLAG_C] = x[8];
      abx_aflags[`ABX_FLAG_N] = x[7];
      abx_aflags[`ABX_FLAG_Z] = (x[7:0] == 8'h00) & (~chain | f[`ABX_FLAG_Z]);
    end
  endfunction

  function [7:0] abx_lflags;
    input [7:0] f;
    input [7:0] r;
    begin
      abx_lflags = f;
      abx_lflags[`ABX_FLAG_Z] = (r == 8'h00);
      abx_lflags[`ABX_FLAG_N] = r[7];
      abx_lflags[`ABX_FLAG_V] = 1'b0;
    end
  endfunction

  function [7:0] abx_wflags;
    input [7:0] f;
    input [15:0] r;
    input v;
    input c;
    begin
      abx_wflags = f;
      abx_wflags[`ABX_FLAG_Z] = (r == 16'h0000);
      abx_wflags[`ABX_FLAG_N] = r[15];
      abx_wflags[`ABX_FLAG_V] = v;
      abx_wflags[`ABX_FLAG_C] = c;
      abx_wflags[`ABX_FLAG_S] = r[15] ^ v;
    end
  endfunction

  always @*
  begin
    next_state = ST_EXEC;
    next_cnt = 3'h0;
    next_pc = pc_inc;
    next_flags = o_status_flags;
    next_we = 1'b0;
    next_wword = 1'b0;
    next_waddr = hd;
    next_wdata = 16'h0000;
    next_push = 1'b0;
    next_pop = 1'b0;
    hvcr = 11'h000;
    wsum = 17'h00000;
    da = regs[hd];
    case (state)
      ST_SKIP:
      begin
        // A skipped two-word instruction costs one more cycle.
        if (op == `ABX_OP_LONG)
        begin
          next_pc = o_pm_addr + 16'h0002;
          next_state = ST_STALL;
        end
      end
      ST_STALL:
      begin
        next_pc = o_pm_addr;
        if (cnt != 3'h0)
        begin
          next_state = ST_STALL;
          next_cnt = cnt - 3'h1;
        end
      end
      default:
      begin
        case (op)
          `ABX_OP_REGREG:
          begin
            da = regs[rd];
            next_waddr = rd;
            case (sub)
              `ABX_RR_ADD_CARRY:
              begin
                hvcr = abx_add8(da, regs[rr], o_status_flags[`ABX_FLAG_C]);
                next_flags = abx_aflags(o_status_flags, hvcr, 1'b0);
                next_we = 1'b1;
              end
              `ABX_RR_SUBTRACT_BORROW_REGS:
              begin
                hvcr = abx_sub8(da, regs[rr], o_status_flags[`ABX_FLAG_C]);
                next_flags = abx_aflags(o_status_flags, hvcr, 1'b1);
                next_we = 1'b1;
              end
              `ABX_RR_COMPARE_SKIP_EQUAL:
              begin
                if (da == regs[rr])
                begin
                  next_state = ST_SKIP;
                end
              end
              default:
              begin
                next_pc = pc_inc;
              end
            endcase
            next_wdata = {8'h00, hvcr[7:0]};
          end
          `ABX_OP_SUBTRACT_IMMEDIATE, `ABX_OP_SUBTRACT_BORROW_IMMEDIATE,
          `ABX_OP_COMPARE_IMMEDIATE:
          begin
            hvcr = abx_sub8(da, kimm, (op == `ABX_OP_SUBTRACT_BORROW_IMMEDIATE) &
              o_status_flags[`ABX_FLAG_C]);
            next_flags = abx_aflags(o_status_flags, hvcr,
              op == `ABX_OP_SUBTRACT_BORROW_IMMEDIATE);
            next_we = (op != `ABX_OP_COMPARE_IMMEDIATE);
            next_wdata = {8'h00, hvcr[7:0]};
          end
          `ABX_OP_AND_IMMEDIATE:
          begin
            next_wdata = {8'h00, da & kimm};
            next_flags = abx_lflags(o_status_flags, da & kimm);
            next_we = 1'b1;
          end
          `ABX_OP_BIT_SET_MASK:
          begin
            next_wdata = {8'h00, da | kimm};
            next_flags = abx_lflags(o_status_flags, da | kimm);
            next_we = 1'b1;
          end
          `ABX_OP_BIT_CLEAR_MASK:
          begin
            next_wdata = {8'h00, da & (8'hFF - kimm)};
            next_flags = abx_lflags(o_status_flags, da & (8'hFF - kimm));
            next_we = 1'b1;
          end
          `ABX_OP_WORD:
          begin
            next_waddr = wlo;
            next_we = 1'b1;
            next_wword = 1'b1;
            next_state = ST_STALL;
            next_cnt = `ABX_CYC_WORD - 3'h2;
            if (i_pm_data[11])
            begin
              wsum = {1'b0, wval} - {1'b0, wk};
              next_flags = abx_wflags(o_status_flags, wsum[15:0],
                wval[15] & ~wsum[15], wsum[15] & ~wval[15]);
            end
            else
            begin
              wsum = {1'b0, wval} + {1'b0, wk};
              next_flags = abx_wflags(o_status_flags, wsum[15:0],
                ~wval[15] & wsum[15], ~wsum[15] & wval[15]);
            end
            next_wdata = wsum[15:0];
          end
          `ABX_OP_SINGLE:
          begin
            da = regs[rd];
            next_waddr = rd;
            next_wdata = {8'h00, da - 8'h01};
            case (sub)
              `ABX_SG_DECREMENT:
              begin
                next_we = 1'b1;
                next_flags = abx_lflags(o_status_flags, da - 8'h01);
                next_flags[`ABX_FLAG_V] = (da == 8'h80);
              end
              `ABX_SG_ZERO_SIGN_TEST:
              begin
                next_flags = abx_lflags(o_status_flags, da & da);
              end
              `ABX_SG_SKIP_IF_REG_BIT_CLEAR:
              begin
                if (!da[i_pm_data[2:0]])
                begin
                  next_state = ST_SKIP;
                end
              end
              default:
              begin
                if (da[i_pm_data[2:0]])
                begin
                  next_state = ST_SKIP;
                end
              end
            endcase
          end
          `ABX_OP_IO_SKIP:
          begin
            if (i_io_regs[{i_pm_data[10:5], i_pm_data[2:0]}] == i_pm_data[11])
            begin
              next_state = ST_SKIP;
            end
          end
          `ABX_OP_BRANCH:
          begin
            if (o_status_flags[i_pm_data[2:0]] == i_pm_data[11])
            begin
              next_pc = br_target;
              next_state = ST_STALL;
            end
          end
          `ABX_OP_RELATIVE_CALL:
          begin
            next_pc = call_target;
            next_push = 1'b1;
            next_state = ST_STALL;
            next_cnt = `ABX_CYC_CALL - 3'h2;
          end
          `ABX_OP_MISC:
          begin
            next_state = ST_STALL;
            case (i_pm_data[3:0])
              `ABX_MS_JUMP_VIA_Z:
              begin
                next_pc = zptr;
                next_cnt = `ABX_CYC_JUMP - 3'h2;
              end
              `ABX_MS_CALL_VIA_Z:
              begin
                next_pc = zptr;
                next_push = 1'b1;
                next_cnt = `ABX_CYC_CALL - 3'h2;
              end
              `ABX_MS_SUBROUTINE_EXIT, `ABX_MS_INTERRUPT_EXIT:
              begin
                next_pc = stack[sp_top];
                next_pop = 1'b1;
                next_cnt = `ABX_CYC_RET - 3'h2;
                if (i_pm_data[3:0] == `ABX_MS_INTERRUPT_EXIT)
                begin
                  next_flags[`ABX_FLAG_I] = 1'b1;
                end
              end
              default:
              begin
                next_state = ST_EXEC;
              end
            endcase
          end
          `ABX_OP_LONG:
          begin
            next_pc = o_pm_addr + 16'h0002;
            next_state = ST_STALL;
            next_cnt = `ABX_CYC_LONG - 3'h2;
          end
          default:
          begin
            next_pc = pc_inc;
          end
        endcase
      end
    endcase
  end

  // The stack wraps silently; software must keep call depth within its size.
  always @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state <= ST_EXEC;
      cnt <= 3'h0;
      sp <= 4'h0;
      o_pm_addr <= `ABX_PC_RESET;
      o_status_flags <= `ABX_FLAGS_RESET;
      o_wr_valid <= 1'b0;
      o_wr_addr <= 5'h00;
      o_wr_data <= 16'h0000;
      o_busy <= 1'b0;
      for (i = 0; i < 32; i = i + 1)
      begin
        regs[i] <= 8'h00;
      end
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      o_pm_addr <= next_pc;
      o_status_flags <= next_flags;
      o_wr_valid <= next_we;
      o_wr_addr <= next_waddr;
      o_wr_data <= next_wdata;
      o_busy <= (next_state != ST_EXEC);
      if (next_we)
      begin
        regs[next_waddr] <= next_wdata[7:0];
        if (next_wword)
        begin
          regs[next_waddr + 5'h01] <= next_wdata[15:8];
        end
      end
      if (next_push)
      begin
        sp <= sp + 4'h1;
      end
      else if (next_pop)
      begin
        sp <= sp_top;
      end
    end
  end

  always @(posedge i_sys_clk)
  begin
    if (!i_sys_rst && next_push)
    begin
      stack[sp] <= pc_inc;
    end
  end

endmodule // abx_exec_core

// ---- verification/abx_pm_model.sv ----
// Purpose: Program memory model that answers instruction words for the core.
// Assumes: Reads are combinational from the fetch address; the bench loads the words.
// Notes: Words that were never loaded read as the erased pattern, a two-word no-op.
`timescale 1ns/1ps
module abx_pm_model
(
  input wire [15:0] i_addr,
  output wire [15:0] o_data
);
  logic [15:0] mem [64];
  initial
  begin
    foreach (mem[i])
      mem[i] = 16'hffff;
  end
  // The upper address bits are not decoded, so a runaway fetch wraps instead of reading X.
  assign o_data = mem[i_addr[5:0]];
endmodule // abx_pm_model

// ---- verification/abx_exec_assertions.sv ----
// Purpose: Port-level assertions for the abx execution core.
// Assumes: One clock domain; reset is asynchronous and active high.
// Notes: An instruction word is executed only in a cycle where o_busy is low.
`timescale 1ns/1ps
`include "abx_consts.vh"
module abx_exec_assertions
(
  input wire i_sys_clk,
  input wire i_sys_rst,
  input wire [15:0] i_pm_data,
  input wire [511:0] i_io_regs,
  input wire [15:0] o_pm_addr,
  input wire [7:0] o_status_flags,
  input wire o_wr_valid,
  input wire [4:0] o_wr_addr,
  input wire [15:0] o_wr_data,
  input wire o_busy
);
  wire ex = !o_busy;
  wire [3:0] op = i_pm_data[15:12];
  wire [7:0] kk = i_pm_data[7:0];
  wire misc = ex && op == `ABX_OP_MISC;
  wire take = o_status_flags[i_pm_data[2:0]] == i_pm_data[11];
  // Branch target for the word under execution, held as a net so that $past sees a signal.
  wire [15:0] br_dest = o_pm_addr + 16'h0001 + {{9{i_pm_data[9]}}, i_pm_data[9:3]};
  wire skip_io = i_io_regs[{i_pm_data[10:5], i_pm_data[2:0]}] == i_pm_data[11];
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  subtract_immediate_write_a: assert property (ex && op == `ABX_OP_SUBTRACT_IMMEDIATE
    |=> o_wr_valid && !o_busy && o_wr_addr == {1'b1, $past(i_pm_data[11:8])}
    && o_pm_addr == $past(o_pm_addr) + 16'h0001) else $error("subtract write wrong");
  and_mask_a: assert property (ex && op == `ABX_OP_AND_IMMEDIATE
    |=> (o_wr_data[7:0] & ~$past(kk)) == 8'h00 && o_status_flags[2] == o_wr_data[7]
    && o_status_flags[0] == $past(o_status_flags[0])) else $error("and mask wrong");
  clear_mask_a: assert property (ex && op == `ABX_OP_BIT_CLEAR_MASK
    |=> o_wr_valid && (o_wr_data[7:0] & $past(kk)) == 8'h00) else $error("clear mask wrong");
  word_two_cyc_a: assert property (ex && op == `ABX_OP_WORD
    |=> o_wr_valid && o_busy && o_wr_addr == {2'b11, $past(i_pm_data[10:9]), 1'b0}
    ##1 !o_busy) else $error("word op wrong");
  skip_eq_flags_a: assert property (ex && op == `ABX_OP_REGREG
    && i_pm_data[11:10] == `ABX_RR_COMPARE_SKIP_EQUAL |=> $stable(o_status_flags)
    && !o_wr_valid) else $error("compare skip changed state");
  io_skip_a: assert property (ex && op == `ABX_OP_IO_SKIP
    |=> o_busy == $past(skip_io) && $stable(o_status_flags)) else $error("io skip wrong");
  branch_take_a: assert property (ex && op == `ABX_OP_BRANCH && take
    |=> o_busy && o_pm_addr == $past(br_dest) ##1 !o_busy) else $error("branch wrong");
  call_cyc_a: assert property ((misc && i_pm_data[3:0] == `ABX_MS_CALL_VIA_Z)
    || (ex && op == `ABX_OP_RELATIVE_CALL) |=> o_busy[*2] ##1 !o_busy)
    else $error("call length wrong");
  ret_cyc_a: assert property (misc && i_pm_data[3:1] == 3'h1
    |=> o_busy[*3] ##1 !o_busy) else $error("return length wrong");
  interrupt_exit_flag_a: assert property (misc && i_pm_data[3:0] == `ABX_MS_INTERRUPT_EXIT
    |-> ##5 o_status_flags[`ABX_FLAG_I]) else $error("interrupt exit left I clear");
  cover property (ex && op == `ABX_OP_WORD);
  cover property (o_busy ##1 o_busy ##1 !o_busy);
  cover property (misc && i_pm_data[3:0] == `ABX_MS_INTERRUPT_EXIT);
endmodule // abx_exec_assertions

bind abx_exec_core abx_exec_assertions u_chk (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
  .i_pm_data(i_pm_data), .i_io_regs(i_io_regs), .o_pm_addr(o_pm_addr),
  .o_status_flags(o_status_flags), .o_wr_valid(o_wr_valid), .o_wr_addr(o_wr_addr),
  .o_wr_data(o_wr_data), .o_busy(o_busy));

// ---- verification/abx_exec_core_tb_top.sv ----
// Purpose: Self-checking bench for the abx execution core.
// Assumes: Reset clears the register file; program memory answers combinationally.
// Notes: Rows hold one-cycle ALU cases; control flow is checked by hand after them.
`timescale 1ns/1ps
module abx_exec_core_tb_top;
  typedef struct {logic [15:0] ins; logic [1:0] wm; logic [4:0] wa; logic [15:0] wd;
    logic [7:0] fl;} abx_row_t;
  logic i_sys_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [511:0] i_io_regs = 512'h0;
  wire [15:0] pm_data;
  wire [15:0] o_pm_addr;
  wire [7:0] o_status_flags;
  wire o_wr_valid;
  wire [4:0] o_wr_addr;
  wire [15:0] o_wr_data;
  wire o_busy;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  // Write mode 2 means the write strobe is not judged for that row.
  abx_row_t rows [11] = '{
    '{16'h10f0, 2'h1, 5'h10, 16'h0010, 8'h01},
    '{16'h1101, 2'h1, 5'h11, 16'h00ff, 8'h25},
    '{16'h0211, 2'h1, 5'h10, 16'h0010, 8'h21},
    '{16'h310f, 2'h1, 5'h11, 16'h000f, 8'h21},
    '{16'h0630, 2'h1, 5'h11, 16'h00fe, 8'h05},
    '{16'h2200, 2'h1, 5'h12, 16'h00ff, 8'h25},
    '{16'h4380, 2'h1, 5'h13, 16'h0080, 8'h25},
    '{16'h520f, 2'h1, 5'h12, 16'h00f0, 8'h25},
    '{16'h6010, 2'h0, 5'h00, 16'h0000, 8'h02},
    '{16'h8260, 2'h1, 5'h13, 16'h007f, 8'h08},
    '{16'h8640, 2'h0, 5'h00, 16'h0000, 8'h04}};
  logic [15:0] prog [16] = '{16'h703f, 16'h7a01, 16'ha810, 16'ha829, 16'h98a3, 16'ha3e9,
    16'h8a00, 16'hf000, 16'he000, 16'h0a10, 16'he000, 16'h1ed8, 16'hc001, 16'hb00a,
    16'h1ef6, 16'hc000};

  abx_exec_core u_dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_pm_data(pm_data),
    .i_io_regs(i_io_regs), .o_pm_addr(o_pm_addr), .o_status_flags(o_status_flags),
    .o_wr_valid(o_wr_valid), .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data), .o_busy(o_busy));
  abx_pm_model u_pm (.i_addr(o_pm_addr), .o_data(pm_data));

  initial
  begin
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // The whole program runs in well under two hundred cycles.
  always @(posedge i_sys_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic check_idle();
    check("pc", o_pm_addr, 16'h0000);
    check("flags", {8'h00, o_status_flags}, 16'h0000);
    check("busy_wr", {14'h0000, o_busy, o_wr_valid}, 16'h0000);
  endtask

  // Called at a falling edge; counts edges until the core leaves its stall or skip cycles.
  task automatic run_op(input logic [15:0] pc, input int cyc, input logic [1:0] wm,
      input logic [4:0] wa, input logic [15:0] wd, input logic [7:0] fl);
    int n;
    n = 1;
    @(negedge i_sys_clk);
    if (wm != 2'h2)
      check("wr_valid", {15'h0000, o_wr_valid}, {15'h0000, wm[0]});
    if (wm == 2'h1)
    begin
      check("wr_addr", {11'h000, o_wr_addr}, {11'h000, wa});
      check("wr_data", o_wr_data, wd);
    end
    while (o_busy === 1'b1 && n < 8)
    begin
      @(negedge i_sys_clk);
      n++;
    end
    check("cycles", 16'(n), 16'(cyc));
    check("pc", o_pm_addr, pc);
    check("flags", {8'h00, o_status_flags}, {8'h00, fl});
  endtask

  initial
  begin
    i_io_regs[43] = 1'b1;
    @(negedge i_sys_clk);
    for (int i = 0; i < 11; i++)
      u_pm.mem[i] = rows[i].ins;
    for (int i = 0; i < 16; i++)
      u_pm.mem[11 + i] = prog[i];
    u_pm.mem[35] = 16'hc003;
    u_pm.mem[40] = 16'hc002;
    u_pm.mem[50] = 16'h90a3;
    u_pm.mem[51] = 16'h8e04;
    u_pm.mem[52] = 16'he000;
    u_pm.mem[53] = 16'ha007;
    repeat (4) @(negedge i_sys_clk);
    check_idle();
    i_sys_rst = 1'b0;
    foreach (rows[i])
      run_op(16'(i + 1), 1, rows[i].wm, rows[i].wa, rows[i].wd, rows[i].fl);
    run_op(16'h000c, 2, 2'h1, 5'h18, 16'h003f, 8'h00);
    run_op(16'h000d, 2, 2'h1, 5'h1a, 16'hffff, 8'h15);
    run_op(16'h0010, 2, 2'h0, 5'h00, 16'h0000, 8'h15);
    run_op(16'h000e, 2, 2'h0, 5'h00, 16'h0000, 8'h15);
    run_op(16'h000f, 1, 2'h0, 5'h00, 16'h0000, 8'h15);
    run_op(16'h0011, 2, 2'h0, 5'h00, 16'h0000, 8'h15);
    run_op(16'h0014, 3, 2'h0, 5'h00, 16'h0000, 8'h15);
    run_op(16'h0016, 2, 2'h0, 5'h00, 16'h0000, 8'h15);
    run_op(16'h0017, 1, 2'h1, 5'h1e, 16'h0028, 8'h31);
    run_op(16'h0028, 3, 2'h0, 5'h00, 16'h0000, 8'h31);
    run_op(16'h0018, 4, 2'h0, 5'h00, 16'h0000, 8'h31);
    run_op(16'h0023, 3, 2'h0, 5'h00, 16'h0000, 8'h31);
    run_op(16'h0019, 4, 2'h0, 5'h00, 16'h0000, 8'hb1);
    run_op(16'h001a, 1, 2'h1, 5'h1e, 16'h0032, 8'h91);
    run_op(16'h0032, 2, 2'h0, 5'h00, 16'h0000, 8'h91);
    run_op(16'h0033, 1, 2'h0, 5'h00, 16'h0000, 8'h91);
    run_op(16'h0035, 2, 2'h0, 5'h00, 16'h0000, 8'h91);
    run_op(16'h0036, 1, 2'h0, 5'h00, 16'h0000, 8'h91);
    i_sys_rst = 1'b1;
    @(negedge i_sys_clk);
    check_idle();
    i_sys_rst = 1'b0;
    // A cleared register file makes the first word give the same result as after power-up.
    run_op(16'h0001, 1, 2'h1, 5'h10, 16'h0010, 8'h01);
    end_of_test();
  end
endmodule // abx_exec_core_tb_top
